// ### hw/ecsf_status.v
// Interrupt control and state status fields of the exception controller
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`default_nettype none
`include "ecsf_defines.vh"

module ecsf_status (
    input  wire                                   clk,
    input  wire                                   reset,
    input  wire [`ECSF_ADDR_W-1:0]                addr,
    input  wire [31:0]                            wdata,
    input  wire                                   wr_en,
    input  wire                                   rd_en,
    output reg  [31:0]                            rdata,
    input  wire [`ECSF_NUM_EXC-1:0]               pend_in,
    input  wire [`ECSF_NUM_EXC-1:0]               enable_in,
    input  wire [`ECSF_NUM_EXC-1:0]               active_in,
    input  wire [`ECSF_NUM_EXC*`ECSF_PRIO_W-1:0]  prio_in,
    input  wire [`ECSF_PRIO_W-1:0]                base_priority_mask,
    input  wire                                   fault_mask_a,
    input  wire [`ECSF_PRIO_W-1:0]                exec_prio,
    input  wire [`ECSF_EXC_W-1:0]                 interrupt_program_status,
    input  wire                                   timer_event,
    output wire                                   timer_pending,
    output wire                                   switch_clear_pulse,
    output wire                                   irq
);

    reg  [`ECSF_EV_W-1:0] status_reg;
    reg  [`ECSF_EV_W-1:0] mask_reg;
    reg                   timer_pend_reg;
    reg  [`ECSF_EV_W-1:0] ev;
    reg  [`ECSF_EXC_W-1:0]  best_num;
    reg  [`ECSF_PRIO_W-1:0] best_prio;
    reg                   best_vld;
    reg                   irq_any;
    reg  [6:0]            act_cnt;
    reg  [`ECSF_PRIO_W-1:0] p;
    reg                   elig;
    integer               i;
    wire                  ics_wr;
    wire [`ECSF_EXC_W-1:0] pending_vector;
    wire [`ECSF_EXC_W-1:0] active_vector;
    wire                  return_to_base;
    wire                  debug_exit_preempt;
    reg  [31:0]           ics_read;

    assign ics_wr = wr_en && (addr == `ECSF_OFF_ICS);
    assign switch_clear_pulse = ics_wr && wdata[`ECSF_BIT_SWITCH_CLR];
    assign timer_pending = timer_pend_reg;

    // Set from software or the timer wins over a same-cycle clear
    always @(posedge clk) begin
        if (reset) begin
            timer_pend_reg <= 1'b0;
        end else if (timer_event || (ics_wr && wdata[`ECSF_BIT_TIMER_SET])) begin
            timer_pend_reg <= 1'b1;
        end else if (ics_wr && wdata[`ECSF_BIT_TIMER_CLR]) begin
            timer_pend_reg <= 1'b0;
        end
    end

    // Highest priority pending enabled exception; lowest number breaks ties
    always @* begin
        best_num  = {`ECSF_EXC_W{1'b0}};
        best_prio = {`ECSF_PRIO_W{1'b1}};
        best_vld  = 1'b0;
        irq_any   = 1'b0;
        act_cnt   = 7'h0;
        p         = {`ECSF_PRIO_W{1'b0}};
        elig      = 1'b0;
        for (i = 1; i < `ECSF_NUM_EXC; i = i + 1) begin
            p = prio_in[i*`ECSF_PRIO_W +: `ECSF_PRIO_W];
            if (active_in[i]) begin
                act_cnt = act_cnt + 7'h1;
            end
            if (i >= `ECSF_FIRST_IRQ && pend_in[i] && enable_in[i]) begin
                irq_any = 1'b1;
            end
            // NMI bypasses both masks; others obey base_priority_mask and fault_mask_a
            elig = pend_in[i] && enable_in[i] &&
                   ((i == `ECSF_EXC_NMI) ||
                    (!fault_mask_a &&
                     (base_priority_mask == {`ECSF_PRIO_W{1'b0}} ||
                      p < base_priority_mask)));
            if (elig && (!best_vld || p < best_prio)) begin
                best_vld  = 1'b1;
                best_num  = i[`ECSF_EXC_W-1:0];
                best_prio = p;
            end
        end
    end

    assign pending_vector = best_vld ? best_num : {`ECSF_EXC_W{1'b0}};
    assign active_vector = interrupt_program_status;
    assign return_to_base = (act_cnt <= 7'h1);
    // Taken on debug exit only if it would preempt current execution
    assign debug_exit_preempt = best_vld && (best_prio < exec_prio);

    always @* begin
        ics_read = 32'h0;
        ics_read[`ECSF_BIT_TIMER_SET]   = timer_pend_reg;
        ics_read[`ECSF_BIT_DBG_PREEMPT] = debug_exit_preempt;
        ics_read[`ECSF_BIT_IRQ_PEND]    = irq_any;
        ics_read[`ECSF_PV_HI:`ECSF_PV_LO] = pending_vector;
        ics_read[`ECSF_BIT_RET_BASE]    = return_to_base;
        ics_read[`ECSF_AV_HI:`ECSF_AV_LO] = active_vector;
        // Clear bits read zero, which is a legal unknown value
    end

    always @* begin
        ev = {`ECSF_EV_W{1'b0}};
        ev[`ECSF_EV_TIMER_PEND] = timer_event && !timer_pend_reg;
        ev[`ECSF_EV_SWITCH_CLR] = switch_clear_pulse;
    end

    always @(posedge clk) begin
        if (reset) begin
            status_reg <= `ECSF_STATUS_RESET;
            mask_reg   <= `ECSF_MASK_RESET;
        end else begin
            if (wr_en && addr == `ECSF_OFF_IRQ_STATUS) begin
                status_reg <= (status_reg & ~wdata[`ECSF_EV_W-1:0]) | ev;
            end else begin
                status_reg <= status_reg | ev;
            end
            if (wr_en && addr == `ECSF_OFF_IRQ_MASK) begin
                mask_reg <= wdata[`ECSF_EV_W-1:0];
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    always @(posedge clk) begin
        if (reset) begin
            rdata <= 32'h0;
        end else if (rd_en) begin
            case (addr)
                `ECSF_OFF_ICS:        rdata <= ics_read;
                `ECSF_OFF_IRQ_STATUS: rdata <= {{(32-`ECSF_EV_W){1'b0}}, status_reg};
                `ECSF_OFF_IRQ_MASK:   rdata <= {{(32-`ECSF_EV_W){1'b0}}, mask_reg};
                default:              rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

endmodule
`default_nettype wire

// ### include/ecsf_defines.vh
// Register layout and field constants for the exception state status fields
`ifndef ECSF_DEFINES_VH
`define ECSF_DEFINES_VH

`define ECSF_ADDR_W            4
`define ECSF_OFF_ICS           4'h0
`define ECSF_OFF_IRQ_STATUS    4'h1
`define ECSF_OFF_IRQ_MASK      4'h2

`define ECSF_BIT_TIMER_SET     26
`define ECSF_BIT_TIMER_CLR     25
`define ECSF_BIT_TIMER_NS      24
`define ECSF_BIT_DBG_PREEMPT   23
`define ECSF_BIT_IRQ_PEND      22
`define ECSF_PV_HI             20
`define ECSF_PV_LO             12
`define ECSF_BIT_RET_BASE      11
`define ECSF_AV_HI             8
`define ECSF_AV_LO             0
`define ECSF_BIT_SWITCH_CLR    27

`define ECSF_NUM_EXC           48
`define ECSF_EXC_W             9
`define ECSF_PRIO_W            8
`define ECSF_FIRST_IRQ         16
`define ECSF_EXC_SWITCH        14
`define ECSF_EXC_TIMER         15
`define ECSF_EXC_NMI           2

// Interrupt status bits
`define ECSF_EV_TIMER_PEND     0
`define ECSF_EV_SWITCH_CLR     1
`define ECSF_EV_W              2
`define ECSF_STATUS_RESET      2'h0
`define ECSF_MASK_RESET        2'h0

`endif

// ### test/ecsf_chk.sv
// Assertions on the status fields register port
`default_nettype none
`include "ecsf_defines.vh"
module ecsf_chk (
    input wire logic [31:0]              wdata,
    input wire logic [31:0]              rdata,
    input wire logic [`ECSF_ADDR_W-1:0]  addr,
    input wire logic [`ECSF_EXC_W-1:0]   interrupt_program_status,
    input wire logic                     clk,
    input wire logic                     reset,
    input wire logic                     wr_en,
    input wire logic                     rd_en,
    input wire logic                     timer_event,
    input wire logic                     timer_pending,
    input wire logic                     switch_clear_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic ics_wr = wr_en && addr == `ECSF_OFF_ICS;
    wire logic ics_rd = rd_en && addr == `ECSF_OFF_ICS;
    property p_av; $past(ics_rd) |-> rdata[8:0] == $past(interrupt_program_status); endproperty
    a_av: assert property (p_av) else $error("active vector mismatch");
    property p_clr; ics_wr && wdata[25] && !wdata[26] && !timer_event |=> !timer_pending;
    endproperty
    a_clr: assert property (p_clr) else $error("timer clear missed");
    property p_set; ics_wr && wdata[26] |=> timer_pending; endproperty
    a_set: assert property (p_set) else $error("timer set missed");
    property p_hold; !ics_wr && !timer_event |=> $stable(timer_pending); endproperty
    a_hold: assert property (p_hold) else $error("timer pending moved");
    property p_sw; switch_clear_pulse == (ics_wr && wdata[27]); endproperty
    a_sw: assert property (p_sw) else $error("switch clear pulse wrong");
    property p_rsv; $past(ics_rd) |-> {rdata[31:28], rdata[24], rdata[21], rdata[10:9]} == 0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_ts; $past(ics_rd) |-> rdata[26] == $past(timer_pending); endproperty
    a_ts: assert property (p_ts) else $error("timer state read wrong");
    property p_unm; $past(rd_en && addr > `ECSF_OFF_IRQ_MASK) |-> rdata == 0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read nonzero");
endmodule
bind ecsf_status ecsf_chk chk_u (.wdata, .rdata, .addr, .interrupt_program_status, .clk,
    .reset, .wr_en, .rd_en, .timer_event, .timer_pending, .switch_clear_pulse);
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the status fields register
`default_nettype none
`include "ecsf_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk, reset, wr_en, rd_en, fm, tev;
    logic [3:0]   addr;
    logic [31:0]  wdata, rdv;
    logic [47:0]  pnd, ena, act;
    logic [383:0] prio;
    logic [7:0]   bpm, xp;
    logic [8:0]   ips;
    wire  [31:0]  rdata;
    wire          tp, irq, scp;
    logic         scp_seen;
    int           error_cnt = 0, compares = 0, cyc = 0;
    ecsf_status dut_u (.clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .pend_in(pnd),
        .enable_in(ena), .active_in(act), .prio_in(prio), .base_priority_mask(bpm),
        .fault_mask_a(fm), .exec_prio(xp), .interrupt_program_status(ips),
        .timer_event(tev), .timer_pending(tp), .switch_clear_pulse(scp), .irq);
    task automatic chk(input logic [31:0] s, e, input string n);
        #1;
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge clk);
        {wr_en, rd_en} <= 2'h0;
        #1 rdv = rdata;
    endtask
    // Bit 25 masked: write-only, its read value is undefined
    task automatic ics(input string n, input logic [8:0] pv, av, input logic ts, pr, ip, rb);
        acc(0, `ECSF_OFF_ICS, 0);
        chk(rdv & 32'hfdff_ffff, {5'h0, ts, 2'h0, pr, ip, 1'h0, pv, rb, 2'h0, av}, n);
    endtask
    task automatic wrap_up;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (scp) scp_seen <= 1'b1;
        if (cyc == 2000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        {wr_en, rd_en, fm, tev, addr, wdata, pnd, ena, act, prio, bpm, xp, ips} = '0;
        scp_seen = 1'b0;
        reset = 1;
        repeat (3) @(posedge clk);
        reset <= 0;
        ics("idle", 0, 0, 0, 0, 0, 1);
        acc(0, 4'h3, 0);
        chk(rdv, 0, "unmapped");
        $display("test idle done");
        acc(1, `ECSF_OFF_IRQ_MASK, 32'h3);
        @(posedge clk);
        tev <= 1;
        @(posedge clk);
        tev <= 0;
        ics("timer event", 0, 0, 1, 0, 0, 1);
        chk(32'(irq), 1, "irq raised");
        acc(1, `ECSF_OFF_IRQ_STATUS, 32'h1);
        chk(32'(irq), 0, "irq cleared");
        acc(1, `ECSF_OFF_ICS, 32'h0);
        chk(32'(tp), 1, "write zero");
        chk(32'(scp_seen), 0, "no switch clear yet");
        acc(1, `ECSF_OFF_ICS, 32'h0a00_0000);
        chk(32'(tp), 0, "timer clear");
        chk(32'(scp_seen), 1, "switch clear pulse");
        acc(1, `ECSF_OFF_ICS, 32'h0400_0000);
        chk(32'(tp), 1, "timer soft set");
        acc(1, `ECSF_OFF_ICS, 32'h0200_0000);
        chk(32'(tp), 0, "timer clear again");
        acc(0, `ECSF_OFF_IRQ_STATUS, 0);
        chk(rdv & 2, 2, "switch clear event");
        $display("test timer done");
        @(posedge clk);
        {pnd, ena, act, ips, xp} <= {48'h14_0000, 48'hffff_ffff_ffff, 48'h10_0008, 9'd20, 8'h80};
        prio[160+:8] <= 8'h10;
        prio[144+:8] <= 8'h40;
        ics("vectors", 20, 20, 0, 1, 1, 0);
        chk(32'(rdv[20:12] - 9'd16), 4, "irq index");
        @(posedge clk);
        {bpm, xp} <= {8'h10, 8'h0};
        ics("base mask", 0, 20, 0, 0, 1, 0);
        @(posedge clk);
        {bpm, fm, pnd, act} <= {8'h0, 1'h1, 48'h4, 48'h10_0000};
        ics("fault mask", 2, 20, 0, 0, 0, 1);
        $display("test vectors done");
        wrap_up();
    end
endmodule
`default_nettype wire
